// [cmpd_pkg.sv]
// constants and types shared by the control-mode pin decoder
package cmpd_pkg;

  // resolved level of one three-level configuration pin
  typedef enum logic [1:0] {
    CMPD_LOW,
    CMPD_HIGH,
    CMPD_FLOAT
  } cmpd_lvl_t;

  // cycles a pin pattern must hold before it is accepted
  localparam int unsigned CMPD_FILTER_CYCLES = 16;
  localparam int unsigned CMPD_CNT_W         = 8;

  // register byte offsets
  localparam logic [11:0] CMPD_CTRL_OFS   = 12'h000;
  localparam logic [11:0] CMPD_STATUS_OFS = 12'h004;
  localparam logic [11:0] CMPD_LEVELS_OFS = 12'h008;

  // control register fields and reset values
  localparam int unsigned CMPD_CTRL_FREEZE_BIT = 0;
  localparam logic        CMPD_FREEZE_RST      = 1'b0;

  // status register field positions
  localparam int unsigned CMPD_ST_EXT_BIT   = 0;
  localparam int unsigned CMPD_ST_RANGE_BIT = 1;
  localparam int unsigned CMPD_ST_SWING_BIT = 2;
  localparam int unsigned CMPD_ST_EDGE_BIT  = 3;
  localparam int unsigned CMPD_ST_DDR_BIT   = 4;
  localparam int unsigned CMPD_ST_CAL_BIT   = 5;
  localparam int unsigned CMPD_ST_DES_BIT   = 6;
  localparam int unsigned CMPD_ST_SWERR_BIT = 7;

  // values of the decoded settings after reset
  localparam logic CMPD_EXT_RST   = 1'b0;
  localparam logic CMPD_RANGE_RST = 1'b0;
  localparam logic CMPD_SWING_RST = 1'b0;
  localparam logic CMPD_EDGE_RST  = 1'b0;
  localparam logic CMPD_DDR_RST   = 1'b0;
  localparam logic CMPD_CAL_RST   = 1'b0;
  localparam logic CMPD_DES_RST   = 1'b0;

  // idle levels of the serial lines while the serial port is inactive
  localparam logic CMPD_SER_CLK_IDLE  = 1'b0;
  localparam logic CMPD_SER_DATA_IDLE = 1'b0;
  localparam logic CMPD_SER_SEL_IDLE  = 1'b1;

  // window comparator pair to pin level; both set is treated as floating
  function automatic cmpd_lvl_t cmpd_resolve(input logic hi, input logic lo);
    cmpd_resolve = (hi && !lo) ? CMPD_HIGH : ((lo && !hi) ? CMPD_LOW : CMPD_FLOAT);
  endfunction : cmpd_resolve

endpackage : cmpd_pkg

// [cmpd_strap_model.sv]
// board strap model: turns wanted pin levels into window comparator pairs
`timescale 1ns/10ps
`default_nettype none
module cmpd_strap_model
  import cmpd_pkg::*;
(
  input  wire logic [7:0] lvls, // two bits per pin: cal, edge, swing, mode
  output logic      [3:0] hi,
  output logic      [3:0] lo
);
  // high, low or open strap
  // an open pin trips neither comparator, so floating never reads as a level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hi[i] = (lvls[2*i+:2] == CMPD_HIGH);
      lo[i] = (lvls[2*i+:2] == CMPD_LOW);
    end
  end
endmodule : cmpd_strap_model
`default_nettype wire

// [cmpd_top.sv]
// control-mode pin decoder with apb status and control registers
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RULE1 - mode pin high or low gives pin mode; floating gives extended serial mode
// RULE2 - pin mode keeps serial port idle; settings come only from pin levels
// RULE3 - in pin mode the mode pin low gives 650 mV range, high 870 mV
// RULE4 - swing pin high gives 0.70 V, low 0.50 V; floating is undefined
// RULE5 - edge pin high or low picks positive or negative output data edge
// RULE6 - floating edge pin gives double data rate clock; edge choice ignored
// RULE7 - calibration pin high selects long delay, low selects short delay
// RULE8 - floating calibration pin gives short delay and dual-edge sampling
// RULE9 - extended mode routes swing, edge, calibration pins to serial clock, data, select
// RULE10 - each pin resolves to high, low or floating and settings are registered
module cmpd_top
  import cmpd_pkg::*;
#(
  parameter int unsigned FILT_CYC = CMPD_FILTER_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        MODE_PIN_HI,
  input  wire logic        MODE_PIN_LO,
  input  wire logic        SWING_PIN_HI,
  input  wire logic        SWING_PIN_LO,
  input  wire logic        EDGE_PIN_HI,
  input  wire logic        EDGE_PIN_LO,
  input  wire logic        CAL_PIN_HI,
  input  wire logic        CAL_PIN_LO,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             EXT_MODE,
  output logic             RANGE_HIGH,
  output logic             SWING_HIGH,
  output logic             OUTPUT_EDGE_SELECT,
  output logic             DDR_EN,
  output logic             CALIBRATION_DELAY_SELECT,
  output logic             DES_EN,
  output logic             SERIAL_CLOCK_LINE,
  output logic             SERIAL_DATA_LINE,
  output logic             SERIAL_SELECT_LINE
);

  //////////////////////////////////////////////////////////////////////////////
  // pin resolution and settle filter

  logic [7:0]            raw_w;
  logic [7:0]            samp_r;
  logic [7:0]            stab_r;
  logic [CMPD_CNT_W-1:0] cnt_r;
  logic                  freeze_r;
  logic                  settled_w;
  logic                  cnt_top_w;

  // RULE10 each pin to high, low or floating
  assign raw_w     = {cmpd_resolve(CAL_PIN_HI, CAL_PIN_LO),
                      cmpd_resolve(EDGE_PIN_HI, EDGE_PIN_LO),
                      cmpd_resolve(SWING_PIN_HI, SWING_PIN_LO),
                      cmpd_resolve(MODE_PIN_HI, MODE_PIN_LO)};
  assign cnt_top_w = (cnt_r == CMPD_CNT_W'(FILT_CYC - 1));
  assign settled_w = cnt_top_w && (raw_w == samp_r);

  // a pattern must hold a while so slow strap edges never glitch the mode
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      samp_r <= {CMPD_FLOAT, CMPD_FLOAT, CMPD_FLOAT, CMPD_LOW};
      cnt_r  <= '0;
    end else if (raw_w != samp_r) begin
      samp_r <= raw_w;
      cnt_r  <= '0;
    end else if (!cnt_top_w) begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  // RULE10 accepted pattern, held while software freezes it
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stab_r <= {CMPD_FLOAT, CMPD_FLOAT, CMPD_FLOAT, CMPD_LOW};
    end else if (settled_w && !freeze_r) begin
      stab_r <= samp_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // setting decode

  cmpd_lvl_t lvl_mode_w;
  cmpd_lvl_t lvl_swing_w;
  cmpd_lvl_t lvl_edge_w;
  cmpd_lvl_t lvl_cal_w;
  logic      ext_w;
  logic      swing_err_w;

  assign lvl_mode_w  = cmpd_lvl_t'(stab_r[1:0]);
  assign lvl_swing_w = cmpd_lvl_t'(stab_r[3:2]);
  assign lvl_edge_w  = cmpd_lvl_t'(stab_r[5:4]);
  assign lvl_cal_w   = cmpd_lvl_t'(stab_r[7:6]);
  // RULE1 floating mode pin selects extended control
  assign ext_w       = (lvl_mode_w == CMPD_FLOAT);
  assign swing_err_w = !ext_w && (lvl_swing_w == CMPD_FLOAT);

  // settings follow pins only in pin mode; extended mode holds the last ones
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      EXT_MODE                 <= CMPD_EXT_RST;
      RANGE_HIGH               <= CMPD_RANGE_RST;
      SWING_HIGH               <= CMPD_SWING_RST;
      OUTPUT_EDGE_SELECT       <= CMPD_EDGE_RST;
      DDR_EN                   <= CMPD_DDR_RST;
      CALIBRATION_DELAY_SELECT <= CMPD_CAL_RST;
      DES_EN                   <= CMPD_DES_RST;
    end else begin
      EXT_MODE <= ext_w;
      if (!ext_w) begin
        // RULE3 mode pin level sets full-scale range
        RANGE_HIGH <= (lvl_mode_w == CMPD_HIGH);
        // RULE4 floating swing pin keeps the previous swing
        if (!swing_err_w) begin
          SWING_HIGH <= (lvl_swing_w == CMPD_HIGH);
        end
        // RULE5 RULE6 edge choice, ignored under double data rate
        OUTPUT_EDGE_SELECT       <= (lvl_edge_w == CMPD_HIGH);
        DDR_EN                   <= (lvl_edge_w == CMPD_FLOAT);
        // RULE7 RULE8 floating gives short delay plus dual-edge sampling
        CALIBRATION_DELAY_SELECT <= (lvl_cal_w == CMPD_HIGH);
        DES_EN                   <= (lvl_cal_w == CMPD_FLOAT);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial line routing

  // RULE2 RULE9 pins become serial lines only in extended mode
  // one flop only: the serial clock is far slower than the core clock
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SERIAL_CLOCK_LINE  <= CMPD_SER_CLK_IDLE;
      SERIAL_DATA_LINE   <= CMPD_SER_DATA_IDLE;
      SERIAL_SELECT_LINE <= CMPD_SER_SEL_IDLE;
    end else begin
      SERIAL_CLOCK_LINE  <= ext_w ? SWING_PIN_HI : CMPD_SER_CLK_IDLE;
      SERIAL_DATA_LINE   <= ext_w ? EDGE_PIN_HI : CMPD_SER_DATA_IDLE;
      SERIAL_SELECT_LINE <= ext_w ? CAL_PIN_HI : CMPD_SER_SEL_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  logic        hit_ctrl_w;
  logic        hit_stat_w;
  logic        hit_lvl_w;
  logic        mapped_w;
  logic        setup_w;
  logic        wr_w;
  logic [31:0] status_w;
  logic [31:0] rd_mux_w;

  assign hit_ctrl_w = (PADDR == CMPD_CTRL_OFS);
  assign hit_stat_w = (PADDR == CMPD_STATUS_OFS);
  assign hit_lvl_w  = (PADDR == CMPD_LEVELS_OFS);
  assign mapped_w   = hit_ctrl_w || hit_stat_w || hit_lvl_w;
  assign setup_w    = PSEL && !PENABLE;
  assign wr_w       = PSEL && PENABLE && PWRITE && hit_ctrl_w;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !mapped_w;

  always_comb begin
    status_w                    = '0;
    status_w[CMPD_ST_EXT_BIT]   = EXT_MODE;
    status_w[CMPD_ST_RANGE_BIT] = RANGE_HIGH;
    status_w[CMPD_ST_SWING_BIT] = SWING_HIGH;
    status_w[CMPD_ST_EDGE_BIT]  = OUTPUT_EDGE_SELECT;
    status_w[CMPD_ST_DDR_BIT]   = DDR_EN;
    status_w[CMPD_ST_CAL_BIT]   = CALIBRATION_DELAY_SELECT;
    status_w[CMPD_ST_DES_BIT]   = DES_EN;
    status_w[CMPD_ST_SWERR_BIT] = swing_err_w;
  end

  assign rd_mux_w = hit_ctrl_w ? {31'h0000_0000, freeze_r} :
                    hit_stat_w ? status_w :
                    hit_lvl_w  ? {24'h00_0000, stab_r} : 32'h0000_0000;

  // read data captured in setup so it stands through the access cycle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA   <= 32'h0000_0000;
      freeze_r <= CMPD_FREEZE_RST;
    end else begin
      if (setup_w && !PWRITE) begin
        PRDATA <= rd_mux_w;
      end
      if (wr_w) begin
        freeze_r <= PWDATA[CMPD_CTRL_FREEZE_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // sampled reset keeps out attempts from the release edge, where flops still held reset values
  sequence pin_mode_s;
    RST_B && !ext_w;
  endsequence

  sequence settle_s;
    settled_w && !freeze_r;
  endsequence

  mode_select_a : assert property (##1 EXT_MODE == $past(lvl_mode_w == CMPD_FLOAT)) // RULE1
    else $error("mode output does not follow mode pin");
  serial_idle_a : assert property (!EXT_MODE |-> SERIAL_SELECT_LINE && !SERIAL_CLOCK_LINE // RULE2
                                   && !SERIAL_DATA_LINE)
    else $error("serial port active in pin mode");
  full_range_a : assert property (pin_mode_s ##0 lvl_mode_w == CMPD_HIGH |=> RANGE_HIGH) // RULE3
    else $error("high mode pin did not give wide range");
  swing_hold_a : assert property (pin_mode_s ##0 swing_err_w |=> $stable(SWING_HIGH)) // RULE4
    else $error("floating swing pin changed swing");
  edge_pick_a : assert property (pin_mode_s ##0 lvl_edge_w == CMPD_HIGH // RULE5
                                 |=> OUTPUT_EDGE_SELECT && !DDR_EN)
    else $error("high edge pin did not select positive edge");
  ddr_clock_a : assert property (pin_mode_s ##0 lvl_edge_w == CMPD_FLOAT // RULE6
                                 |=> DDR_EN && !OUTPUT_EDGE_SELECT)
    else $error("floating edge pin did not give double data rate");
  cal_delay_a : assert property (pin_mode_s ##0 lvl_cal_w != CMPD_FLOAT // RULE7
                                 |=> CALIBRATION_DELAY_SELECT == $past(lvl_cal_w == CMPD_HIGH)
                                     && !DES_EN)
    else $error("calibration delay does not follow pin");
  des_mode_a : assert property (pin_mode_s ##0 lvl_cal_w == CMPD_FLOAT // RULE8
                                |=> DES_EN && !CALIBRATION_DELAY_SELECT)
    else $error("floating calibration pin did not give dual-edge sampling");
  serial_route_a : assert property (ext_w |=> SERIAL_DATA_LINE == $past(EDGE_PIN_HI) // RULE9
                                    && SERIAL_SELECT_LINE == $past(CAL_PIN_HI)
                                    && SERIAL_CLOCK_LINE == $past(SWING_PIN_HI))
    else $error("serial lines not routed from pins");
  pin_settle_a : assert property (settle_s |=> stab_r == $past(samp_r) ##1 1) // RULE10
    else $error("settled pattern not accepted");

endmodule : cmpd_top

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the control-mode pin decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import cmpd_pkg::*;
;
  localparam int unsigned FC = 2; // short filter keeps the run brief
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  lvls;
  logic [9:0]  hold;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [3:0]  hi;
  wire  [3:0]  lo;
  wire  [9:0]  outs; // ext, range, swing, edge, ddr, cal, des, sclk, serial_data_line, ssel
  int          miscompares;
  int          comparisons;

  cmpd_strap_model cmpd_strap_model_i (.lvls(lvls), .hi(hi), .lo(lo));
  cmpd_top #(.FILT_CYC(FC)) cmpd_top_i (
    .CORE_CLK(clk), .RST_B(rst_b), .MODE_PIN_HI(hi[0]), .MODE_PIN_LO(lo[0]),
    .SWING_PIN_HI(hi[1]), .SWING_PIN_LO(lo[1]), .EDGE_PIN_HI(hi[2]), .EDGE_PIN_LO(lo[2]),
    .CAL_PIN_HI(hi[3]), .CAL_PIN_LO(lo[3]), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_MODE(outs[9]), .RANGE_HIGH(outs[8]), .SWING_HIGH(outs[7]),
    .OUTPUT_EDGE_SELECT(outs[6]), .DDR_EN(outs[5]), .CALIBRATION_DELAY_SELECT(outs[4]),
    .DES_EN(outs[3]), .SERIAL_CLOCK_LINE(outs[2]), .SERIAL_DATA_LINE(outs[1]),
    .SERIAL_SELECT_LINE(outs[0]));

  ////////////////////////////////////////////////////////////////////////////////
  // expected settings in pin mode; edge choice is dropped when ddr runs
  function automatic logic [9:0] exp_pin(input logic [7:0] l);
    exp_pin = {1'b0, l[1:0] == CMPD_HIGH, l[3:2] == CMPD_HIGH,
               l[5:4] == CMPD_HIGH, l[5:4] == CMPD_FLOAT, l[7:6] == CMPD_HIGH,
               l[7:6] == CMPD_FLOAT, 3'b001};
  endfunction : exp_pin

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wrap_up;
    $display("mismatches %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // one apb transfer; holds the request until pready is seen high, giving up after 50 cycles
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pins change after an edge, then the filter gets room to accept them
  task set_pins(input logic [7:0] l);
    @(posedge clk);
    lvls <= l;
    repeat (FC + 4) @(posedge clk);
  endtask : set_pins

  ////////////////////////////////////////////////////////////////////////////////
  // every high/low/open mix in pin mode except an open swing pin, seen at the pins and in status
  task t_pins;
    logic [7:0] l;
    for (int m = 0; m < 2; m++) for (int s = 0; s < 2; s++)
      for (int e = 0; e < 3; e++) for (int c = 0; c < 3; c++) begin
        l = {c[1:0], e[1:0], s[1:0], m[1:0]};
        set_pins(l);
        hold = exp_pin(l);
        chk("pin settings", {22'h0, outs}, {22'h0, hold});
        apb(1'b0, CMPD_STATUS_OFS, 32'h0);
        chk("status", rd,
            {25'h0, hold[3], hold[4], hold[5], hold[6], hold[7], hold[8], 1'b0});
        apb(1'b0, CMPD_LEVELS_OFS, 32'h0);
        chk("levels", rd, {24'h0, l});
      end
  endtask : t_pins

  // open mode pin: serial lines follow the pins a cycle late, settings hold
  task t_ext;
    set_pins({6'b010101, CMPD_FLOAT});
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      lvls[7:2] <= {1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
      repeat (2) @(posedge clk);
      chk("ext lines", {22'h0, outs}, {22'h0, 1'b1, hold[8:3], p[0], p[1], p[2]});
    end
  endtask : t_ext

  // freeze, unmapped access and an open swing pin
  task t_misc;
    set_pins(8'h00);
    chk("all low", {22'h0, outs}, {22'h0, exp_pin(8'h00)});
    apb(1'b1, CMPD_CTRL_OFS, 32'h1);
    apb(1'b0, CMPD_CTRL_OFS, 32'h0);
    chk("freeze", rd, 32'h1);
    set_pins(8'h55);
    chk("frozen", {22'h0, outs}, {22'h0, exp_pin(8'h00)});
    apb(1'b1, CMPD_CTRL_OFS, 32'h0);
    repeat (FC + 4) @(posedge clk);
    chk("thawed", {22'h0, outs}, {22'h0, exp_pin(8'h55)});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    set_pins(8'h59);
    chk("swing open", {22'h0, outs}, {22'h0, exp_pin(8'h55)});
    apb(1'b0, CMPD_STATUS_OFS, 32'h0);
    chk("swing error", {31'h0, rd[CMPD_ST_SWERR_BIT]}, 32'h1);
  endtask : t_misc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    wrap_up;
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lvls = 8'h00;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    chk("reset outs", {22'h0, outs}, 32'h1);
    rst_b <= 1'b1;
    t_pins;
    t_ext;
    t_misc;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
